// >>> logic/pmd_pkg.sv
// package: register map, fields and timing constants of the converter control block
package pmd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DIV      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam int unsigned ADDR_W      = 8;

  // control fields
  localparam int unsigned CTRL_SW_START = 0;
  localparam int unsigned CTRL_FREE     = 1;
  // status fields, count sits in the low bits
  localparam int unsigned ST_SIGN  = 16;
  localparam int unsigned ST_OVR   = 17;
  localparam int unsigned ST_CC    = 18;
  localparam int unsigned ST_REQ   = 19;
  localparam int unsigned ST_BLANK = 20;
  // interrupt event bits
  localparam int unsigned EV_XFER = 0;
  localparam int unsigned EV_OVR  = 1;
  localparam int unsigned EV_W    = 2;

  // converter timing, counted in converter clock periods
  localparam int unsigned CYCLE_TICKS  = 64512;
  localparam int unsigned FULL_SCALE   = 2000;
  localparam int unsigned CC_HOLD      = 64;
  localparam int unsigned MIN_XFER     = 256;
  // display weight of the leading digit, blanked when below it
  localparam int unsigned MSD_WEIGHT   = 1000;
  // converter clock divider reload (period is reload+1 hclk cycles)
  localparam logic [15:0] DIV_RESET    = 16'h0135;
endpackage

// >>> logic/pmd_tick_div.sv
// module: converter clock enable divider
module pmd_tick_div #(
  parameter int unsigned W = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] reload,
  output logic              tick
);
  logic [W-1:0] cnt;

  // one-cycle enable every reload+1 hclk cycles; reload change takes effect at wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt == '0) begin
      cnt  <= reload;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt - 1'b1;
      tick <= 1'b0;
    end
  end

  tick_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && cnt != '0 |=> !tick)
    else $error("converter tick lasted more than one cycle");
endmodule

// >>> logic/pmd_mod_counter.sv
// module: modulation flop, gated pulse and result counter
module pmd_mod_counter #(
  parameter int unsigned CW = 11
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          tick,
  input  wire logic          comparator_in,
  input  wire logic          win_start,
  input  wire logic          win_open,
  output logic               mod_q,
  output logic               gated,
  output logic [CW-1:0]      result
);
  // comparator captured only at converter clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_q <= 1'b0;
    end else if (tick) begin
      mod_q <= comparator_in;
    end
  end

  // clock ANDed with the duty-cycle state
  assign gated = tick & mod_q;

  // accumulate inside the window; first tick of a window restarts the sum
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= '0;
    end else if (tick && win_start) begin
      result <= {{(CW-1){1'b0}}, gated};
    end else if (gated && win_open) begin
      result <= result + 1'b1;
    end
  end

  mod_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !tick |=> $stable(mod_q))
    else $error("modulation flop moved without a converter tick");
  win_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && win_start |=> result <= 1)
    else $error("result not cleared at window start");
endmodule

// >>> logic/pmd_dvm_ctrl.sv
// module: pulse-modulation voltmeter control with AHB-Lite register slave
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
module pmd_dvm_ctrl #(
  parameter int unsigned CYCLE_LEN = pmd_pkg::CYCLE_TICKS,
  parameter int unsigned WIN_LEN   = pmd_pkg::FULL_SCALE,
  parameter int unsigned HOLD_LEN  = pmd_pkg::CC_HOLD,
  parameter int unsigned MIN_WAIT  = pmd_pkg::MIN_XFER,
  parameter int unsigned CW        = 11,
  parameter int unsigned PW        = 16
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          comparator_in,
  input  wire logic          polarity_in,
  input  wire logic          start_conv,
  output logic               reference_switch,
  output logic               conv_complete,
  output logic [CW-1:0]      display_count,
  output logic               display_sign,
  output logic               overrange_flag,
  output logic               msd_blank,
  output logic               irq
);
  // refuse sizes the counters cannot hold
  if (CW < 2 || WIN_LEN >= (1 << CW)) begin : g_bad_cw
    $error("result counter too narrow for the window");
  end
  if (PW > 31 || CYCLE_LEN > (1 << PW) || WIN_LEN >= CYCLE_LEN || MIN_WAIT < 1
      || MIN_WAIT >= CYCLE_LEN || HOLD_LEN < 1 || HOLD_LEN >= CYCLE_LEN) begin : g_bad_pw
    $error("converter timing parameters out of range");
  end

  localparam logic [PW-1:0] LAST_PHASE = PW'(CYCLE_LEN - 1);
  localparam logic [PW-1:0] WIN_PHASE  = PW'(WIN_LEN);
  localparam logic [PW-1:0] WAIT_CNT   = PW'(MIN_WAIT);
  localparam logic [PW-1:0] HOLD_CNT   = PW'(HOLD_LEN);
  localparam logic [CW-1:0] FS_COUNT   = CW'(WIN_LEN);
  localparam logic [CW-1:0] MSD_COUNT  = CW'(pmd_pkg::MSD_WEIGHT);

  // register state
  logic                    free_sw;
  logic [15:0]             div_reload;
  logic [pmd_pkg::EV_W-1:0] int_stat;
  logic [pmd_pkg::EV_W-1:0] int_mask;
  logic                    wr_pend;
  logic [pmd_pkg::ADDR_W-1:0] wr_addr;
  logic                    sw_start;

  // converter state
  logic                    tick;
  logic                    mod_q;
  logic                    gated;
  logic [CW-1:0]           result;
  logic [PW-1:0]           phase;
  logic [PW-1:0]           wait_cnt;
  logic [PW-1:0]           hold_cnt;
  logic                    start_q;
  logic                    req_pending;
  logic                    free_run;
  logic                    start_rise;
  logic                    xfer_free;
  logic                    xfer_req;
  logic                    xfer;
  logic                    ovr_now;
  logic [pmd_pkg::EV_W-1:0] ev;
  logic [pmd_pkg::EV_W-1:0] w1c;
  logic [pmd_pkg::EV_W-1:0] next_int_stat;

  function automatic logic hit(input logic [pmd_pkg::ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  pmd_tick_div #(.W(16)) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .reload  (div_reload),
    .tick    (tick)
  );

  pmd_mod_counter #(.CW(CW)) u_mod (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .tick          (tick),
    .comparator_in (comparator_in),
    .win_start     (phase == '0),
    .win_open      (phase < WIN_PHASE),
    .mod_q         (mod_q),
    .gated         (gated),
    .result        (result)
  );

  // reference switch mirrors the modulation flop from the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reference_switch <= 1'b0;
    end else if (tick) begin
      reference_switch <= comparator_in;
    end
  end

  // conversion phase runs forever, whatever start and complete do
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= '0;
    end else if (tick) begin
      phase <= (phase == LAST_PHASE) ? '0 : phase + 1'b1;
    end
  end

  // transfer decisions; result is final once the window has closed
  assign free_run   = start_conv | free_sw;
  assign start_rise = (start_conv & ~start_q) | sw_start;
  assign xfer_free  = free_run & tick & (phase == LAST_PHASE);
  assign xfer_req   = ~free_run & req_pending & tick & (wait_cnt >= WAIT_CNT)
                      & (phase >= WIN_PHASE);
  assign xfer       = xfer_free | xfer_req;
  assign ovr_now    = (result >= FS_COUNT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_conv;
    end
  end

  // request latch: a new edge wins over the transfer that would clear it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_pending <= 1'b0;
    end else if (start_rise) begin
      req_pending <= 1'b1;
    end else if (xfer) begin
      req_pending <= 1'b0;
    end
  end

  // ticks since the request, saturating so a late transfer never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= '0;
    end else if (start_rise) begin
      wait_cnt <= '0;
    end else if (tick && wait_cnt < WAIT_CNT) begin
      wait_cnt <= wait_cnt + 1'b1;
    end
  end

  // complete flag: edge drops it, transfer raises it, free run times it out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_complete <= 1'b0;
      hold_cnt      <= '0;
    end else if (start_rise) begin
      conv_complete <= 1'b0;
      hold_cnt      <= '0;
    end else if (xfer) begin
      conv_complete <= 1'b1;
      hold_cnt      <= xfer_free ? HOLD_CNT : '0;
    end else if (tick && hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
      if (hold_cnt == PW'(1)) begin
        conv_complete <= 1'b0;
      end
    end
  end

  // display latch, held until the next transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_count  <= '0;
      display_sign   <= 1'b0;
      overrange_flag <= 1'b0;
      msd_blank      <= 1'b1;
    end else if (xfer) begin
      display_count  <= ovr_now ? FS_COUNT : result;
      display_sign   <= polarity_in;
      overrange_flag <= ovr_now;
      msd_blank      <= ~ovr_now & (result < MSD_COUNT);
    end
  end

  // interrupt status: sticky, write one to clear, a new event wins
  assign ev = {xfer & ovr_now, xfer};
  assign w1c = (wr_pend && hit(wr_addr, pmd_pkg::OFS_INT_STAT))
               ? hwdata[pmd_pkg::EV_W-1:0] : '0;
  assign next_int_stat = (int_stat & ~w1c) | ev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat <= '0;
      irq      <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq      <= |(next_int_stat & int_mask);
    end
  end

  // address phase capture; zero wait states so hready is always granted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= hsel & hready & htrans[1] & hwrite;
      wr_addr   <= haddr[pmd_pkg::ADDR_W-1:0];
    end
  end

  // read data registered in the address phase, ready in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata <= '0;
      if (hit(haddr[pmd_pkg::ADDR_W-1:0], pmd_pkg::OFS_CTRL)) begin
        hrdata[pmd_pkg::CTRL_FREE] <= free_sw;
      end else if (hit(haddr[pmd_pkg::ADDR_W-1:0], pmd_pkg::OFS_DIV)) begin
        hrdata[15:0] <= div_reload;
      end else if (hit(haddr[pmd_pkg::ADDR_W-1:0], pmd_pkg::OFS_STATUS)) begin
        hrdata[CW-1:0]             <= display_count;
        hrdata[pmd_pkg::ST_SIGN]   <= display_sign;
        hrdata[pmd_pkg::ST_OVR]    <= overrange_flag;
        hrdata[pmd_pkg::ST_CC]     <= conv_complete;
        hrdata[pmd_pkg::ST_REQ]    <= req_pending;
        hrdata[pmd_pkg::ST_BLANK]  <= msd_blank;
      end else if (hit(haddr[pmd_pkg::ADDR_W-1:0], pmd_pkg::OFS_INT_STAT)) begin
        hrdata[pmd_pkg::EV_W-1:0] <= int_stat;
      end else if (hit(haddr[pmd_pkg::ADDR_W-1:0], pmd_pkg::OFS_INT_MASK)) begin
        hrdata[pmd_pkg::EV_W-1:0] <= int_mask;
      end
    end
  end

  // writable registers; unmapped writes are dropped with an OKAY answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      free_sw    <= 1'b0;
      div_reload <= pmd_pkg::DIV_RESET;
      int_mask   <= '0;
      sw_start   <= 1'b0;
    end else begin
      sw_start <= 1'b0;
      if (wr_pend) begin
        if (hit(wr_addr, pmd_pkg::OFS_CTRL)) begin
          free_sw  <= hwdata[pmd_pkg::CTRL_FREE];
          sw_start <= hwdata[pmd_pkg::CTRL_SW_START];
        end
        if (hit(wr_addr, pmd_pkg::OFS_DIV)) begin
          div_reload <= hwdata[15:0];
        end
        if (hit(wr_addr, pmd_pkg::OFS_INT_MASK)) begin
          int_mask <= hwdata[pmd_pkg::EV_W-1:0];
        end
      end
    end
  end

  // checks on the control sequence
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_req_edge;
    start_rise ##1 (req_pending && !conv_complete);
  endsequence

  sequence s_done;
    conv_complete
      && display_count == ($past(ovr_now) ? FS_COUNT : $past(result));
  endsequence

  ref_follow_a: assert property (tick |=> reference_switch == mod_q)
    else $error("reference switch differs from modulation state");
  gate_and_a: assert property (gated |-> tick && mod_q)
    else $error("gated pulse without modulation state");
  count_step_a: assert property (gated && phase < WIN_PHASE && phase != '0
    |=> result == $past(result) + 1'b1)
    else $error("gated pulse not counted");
  win_full_a: assert property (xfer && mod_q && $past(mod_q) |-> result <= FS_COUNT)
    else $error("count above full scale");
  free_point_a: assert property (xfer && free_run |-> phase == LAST_PHASE)
    else $error("free-running update off the cycle boundary");
  rise_cause_a: assert property ($rose(conv_complete) |-> $past(xfer))
    else $error("complete rose without a transfer");
  done_seq_a: assert property (xfer && !start_rise |=> s_done)
    else $error("display latch not loaded on transfer");
  hold_len_a: assert property (xfer_free && !start_rise
    |=> conv_complete && hold_cnt == HOLD_CNT)
    else $error("complete hold not started");
  req_edge_a: assert property (start_rise |-> s_req_edge)
    else $error("start edge not latched");
  req_early_a: assert property (xfer_req |-> wait_cnt >= WAIT_CNT)
    else $error("requested transfer too early");
  ovr_flag_a: assert property (xfer && ovr_now |=> overrange_flag && !msd_blank)
    else $error("overrange not shown");
  blank_msd_a: assert property (xfer && !ovr_now
    && result < MSD_COUNT |=> msd_blank)
    else $error("leading zero digit not blanked");

  // cycle end: the phase wraps and a fresh window opens
  sequence s_cycle_end;
    tick && phase == LAST_PHASE;
  endsequence

  // start edge, request clear, phase, display latch and complete hold
  drop_start_a: assert property (start_rise |=> !conv_complete)
    else $error("complete not dropped by start edge");
  req_clear_a: assert property (xfer && !start_rise |=> !req_pending)
    else $error("request not cleared by its transfer");
  phase_run_a: assert property (tick && phase != LAST_PHASE
    |=> phase == $past(phase) + 1'b1)
    else $error("conversion phase stalled");
  phase_wrap_a: assert property (s_cycle_end |=> phase == '0)
    else $error("conversion phase did not wrap");
  sign_latch_a: assert property (xfer |=> display_sign == $past(polarity_in))
    else $error("sign not latched with the result");
  latch_hold_a: assert property (!xfer |=> $stable(display_count))
    else $error("display latch changed without a transfer");
  hold_end_a: assert property (tick && hold_cnt == PW'(1) && !start_rise && !xfer
    |=> !conv_complete)
    else $error("complete hold did not end");

  // interrupt status and bus answer
  irq_level_a: assert property ($stable(int_mask) |-> irq == |(int_stat & int_mask))
    else $error("interrupt level differs from masked status");
  stat_sticky_a: assert property (int_stat[pmd_pkg::EV_XFER] && !w1c[pmd_pkg::EV_XFER]
    |=> int_stat[pmd_pkg::EV_XFER])
    else $error("transfer status bit lost");
  set_wins_a: assert property (ev != '0 |=> (int_stat & $past(ev)) == $past(ev))
    else $error("new event lost to a clear");
  okay_resp_a: assert property (hreadyout |-> !hresp)
    else $error("slave answered with an error response");
endmodule

// >>> tb/pmd_loop_model.sv
// partner model: comparator and feedback filter around the converter loop
module pmd_loop_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        reference_switch,
  input  wire logic [10:0] level,
  output logic             comparator_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int acc;
  int next_acc;
  // integrator stands in for the filter; clamp keeps settling short after a step
  always_comb begin
    next_acc = acc + int'(level) - (reference_switch ? 1000 : 0);
    if (next_acc > 4000) next_acc = 4000;
    if (next_acc < -4000) next_acc = -4000;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= 0;
    end else begin
      acc <= next_acc;
    end
  end
  // comparator high while input stands above feedback
  assign comparator_in = (acc > 0);
endmodule

// >>> tb/pmd_dvm_ctrl_tb_top.sv
// self-checking bench for the converter control block
module pmd_dvm_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC  = 600;
  localparam int WIN  = 200;
  localparam int HOLD = 8;
  localparam int MINW = 16;
  typedef struct {
    logic [10:0] cnt;
    logic        sgn;
    logic        ovr;
    logic        chk;
  } pmd_exp_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        comparator_in;
  logic        polarity_in;
  logic        start_conv;
  logic        reference_switch;
  logic        conv_complete;
  logic [10:0] display_count;
  logic        display_sign;
  logic        overrange_flag;
  logic        msd_blank;
  logic        irq;
  logic [10:0] level;
  logic        free_mode;
  logic        cc_prev;
  int          err_count;
  int          checks;
  int          cyc;
  int          rises;
  int          gap;
  int          hi_len;
  pmd_exp_t    exp_q[$];
  pmd_exp_t    e;

  // shortened counts keep the run small; expectations use the same figures
  pmd_dvm_ctrl #(.CYCLE_LEN(CYC), .WIN_LEN(WIN), .HOLD_LEN(HOLD), .MIN_WAIT(MINW)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comparator_in(comparator_in),
    .polarity_in(polarity_in), .start_conv(start_conv), .reference_switch(reference_switch),
    .conv_complete(conv_complete), .display_count(display_count),
    .display_sign(display_sign), .overrange_flag(overrange_flag), .msd_blank(msd_blank),
    .irq(irq));

  pmd_loop_model loop_u (.hclk(hclk), .hresetn(hresetn), .reference_switch(reference_switch),
    .level(level), .comparator_in(comparator_in));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one single word transfer; the wait ends only when the slave answers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string m);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, x, m);
    check({31'h0, hresp}, 32'h0, "response");
  endtask

  // extra edge lets the monitor pop its note before the next one is queued
  task automatic wait_rise();
    do @(posedge hclk); while (!(conv_complete === 1'b1 && cc_prev === 1'b0));
    @(posedge hclk);
  endtask

  // monitor: takes the oldest note at each rise of complete, times the complete pulse
  always @(posedge hclk) begin
    cc_prev <= conv_complete;
    gap++;
    hi_len++;
    if (!free_mode) rises = 0;
    if (conv_complete === 1'b1 && cc_prev === 1'b0) begin
      if (free_mode && rises > 1) check(gap, CYC, "update spacing");
      rises++;
      gap = 0;
      hi_len = 0;
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        if (e.chk && !e.ovr) check({31'h0, (display_count + 11'd2 >= e.cnt) &&
          (display_count <= e.cnt + 11'd2)}, 32'h1, "count");
        if (e.chk) check({31'h0, display_sign}, {31'h0, e.sgn}, "sign");
        if (e.chk) check({31'h0, overrange_flag}, {31'h0, e.ovr}, "ovr");
        if (e.chk) check({31'h0, msd_blank}, {31'h0, !e.ovr}, "blank");
      end
    end
    if (conv_complete === 1'b0 && cc_prev === 1'b1 && free_mode && rises > 1)
      check(hi_len, HOLD, "complete width");
  end

  // cycle ceiling; a hang counts as a mismatch
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    logic [10:0] lv;
    logic        pol;
    logic [31:0] v;
    int          lat;
    hresetn = 1'b0;
    {hsel, hwrite, start_conv, free_mode} = '0;
    htrans = 2'h0;
    haddr = 32'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    polarity_in = 1'b1;
    level = 11'd500;
    void'($urandom(32'hba72));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h04, {16'h0000, pmd_pkg::DIV_RESET}, "divider reset");
    rdc(8'h10, 32'h0, "mask reset");
    wr(8'h40, 32'hffffffff);
    rdc(8'h40, 32'h0, "unmapped");
    wr(8'h04, 32'h0);
    rdc(8'h04, 32'h0, "divider write");
    $display("test registers done");
    // free running: settle a level for one update, check the next one
    free_mode <= 1'b1;
    start_conv <= 1'b1;
    wait_rise();
    for (int i = 0; i < 6; i++) begin
      lv = (i == 0) ? 11'd0 : (i == 1) ? 11'd1000 : (i == 2) ? 11'd500 : 11'($urandom % 900);
      pol = (i == 1) ? 1'b1 : 1'($urandom % 2);
      level <= lv;
      polarity_in <= pol;
      exp_q.push_back('{11'd0, 1'b0, 1'b0, 1'b0});
      exp_q.push_back('{11'(lv * WIN / 1000), pol, lv == 11'd1000, 1'b1});
      wait_rise();
      wait_rise();
    end
    while (conv_complete !== 1'b0) @(posedge hclk);
    start_conv <= 1'b0;
    free_mode <= 1'b0;
    $display("test free running done");
    // requests by pin pulse and by register; the loop never stops meanwhile
    level <= 11'd300;
    polarity_in <= 1'b0;
    repeat (CYC) @(posedge hclk);
    for (int k = 0; k < 2; k++) begin
      exp_q.push_back('{11'(300 * WIN / 1000), 1'b0, 1'b0, 1'b1});
      if (k == 0) begin
        start_conv <= 1'b1;
        @(posedge hclk);
        start_conv <= 1'b0;
      end else begin
        wr(8'h00, 32'h1);
      end
      repeat (3) @(posedge hclk);
      check({31'h0, conv_complete}, 32'h0, "complete drop");
      lat = 4;
      while (conv_complete !== 1'b1 && lat < 2000) begin
        @(posedge hclk);
        lat++;
      end
      check({31'h0, lat >= MINW && lat <= CYC}, 32'h1, "latency");
      repeat (HOLD + 4) @(posedge hclk);
      check({31'h0, conv_complete}, 32'h1, "complete held");
    end
    bus(1'b0, 8'h08, 32'h0, v);
    check({31'h0, v[18]}, 32'h1, "status complete");
    check({31'h0, v[16]}, 32'h0, "status sign");
    $display("test requests done");
    // events: sticky, masked, raised, cleared one bit at a time
    rdc(8'h0c, 32'h3, "events");
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(8'h10, 32'h1);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h1, "irq raised");
    wr(8'h0c, 32'h1);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    rdc(8'h0c, 32'h2, "sticky");
    wr(8'h0c, 32'h2);
    rdc(8'h0c, 32'h0, "all cleared");
    rdc(8'h10, 32'h1, "mask readback");
    $display("test interrupts done");
    // software free-run bit: same update spacing and hold as the pin
    free_mode <= 1'b1;
    wr(8'h00, 32'h2);
    rdc(8'h00, 32'h2, "free bit");
    for (int j = 0; j < 3; j++) begin
      exp_q.push_back('{11'(300 * WIN / 1000), 1'b0, 1'b0, 1'b1});
      wait_rise();
    end
    $display("test software free run done");
    stop_test();
  end
endmodule
